// *** logic/bpc_pkg.sv ***
// Package with shared constants and carrier types for the biphase mark codec
package bpc_pkg;
  // Unit interval at 50 MHz core clock: 300 kbit/s nominal gives 3333 ns
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned UI_NS = 3333;
  localparam int unsigned UI_CYC = UI_NS / CLK_PERIOD_NS;
  localparam int unsigned HALF_CYC = UI_CYC / 2;
  // Receive windows as fractions of the unit interval
  localparam int unsigned RX_MID_LO = (UI_CYC * 3) / 8;
  localparam int unsigned RX_MID_HI = (UI_CYC * 5) / 8;
  localparam int unsigned RX_FULL_LO = (UI_CYC * 3) / 4;
  localparam int unsigned RX_FULL_HI = (UI_CYC * 5) / 4;
  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;

  // Transmit request from the protocol layer
  typedef struct packed {
    logic valid;
    logic data;
    logic last;
  } bpc_tx_bit_t;

  // Decoded receive bit
  typedef struct packed {
    logic valid;
    logic data;
  } bpc_rx_bit_t;

  // Pin carrier for one open channel pin
  typedef struct packed {
    logic out;
    logic oe;
  } bpc_pin_drv_t;

  typedef enum logic [1:0] {
    BPC_TX_IDLE = 2'b00,
    BPC_TX_PRE = 2'b01,
    BPC_TX_BIT = 2'b11,
    BPC_TX_CLOSE = 2'b10
  } bpc_tx_state_t;
endpackage : bpc_pkg

// *** logic/bpc_rx_decoder.sv ***
// Receive decoder measuring edge spacing against the unit interval
`timescale 1ns/10ps
module bpc_rx_decoder #(
  parameter int unsigned CNT_W = bpc_pkg::CNT_W
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic line_in, // Selected line level, synchronous
  input wire logic rx_en, // Decoding allowed
  output bpc_pkg::bpc_rx_bit_t rx_bit // Decoded bit pulse
);
  logic prev_line;
  logic [CNT_W-1:0] gap;
  logic half_seen;
  logic locked;
  logic edge_now;

  assign edge_now = line_in ^ prev_line;

  // Edge spacing measurement and bit decision
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prev_line <= 1'b0;
      gap <= bpc_pkg::CNT_ZERO;
      half_seen <= 1'b0;
      locked <= 1'b0;
      rx_bit <= '0;
    end
    else if (ce)
    begin
      prev_line <= line_in;
      rx_bit.valid <= 1'b0;
      if (!rx_en)
      begin
        gap <= bpc_pkg::CNT_ZERO;
        half_seen <= 1'b0;
        locked <= 1'b0;
      end
      else if (edge_now)
      begin
        gap <= bpc_pkg::CNT_ZERO;
        // Any first edge seen just arms timing, so a lost first edge is harmless
        if (!locked)
          locked <= 1'b1;
        else if (gap >= CNT_W'(bpc_pkg::RX_FULL_LO) && gap <= CNT_W'(bpc_pkg::RX_FULL_HI))
        begin
          rx_bit.valid <= 1'b1;
          rx_bit.data <= 1'b0;
          half_seen <= 1'b0;
        end
        else if (gap >= CNT_W'(bpc_pkg::RX_MID_LO) && gap <= CNT_W'(bpc_pkg::RX_MID_HI))
        begin
          if (half_seen)
          begin
            rx_bit.valid <= 1'b1;
            rx_bit.data <= 1'b1;
          end
          half_seen <= ~half_seen;
        end
        else
        begin
          // Out of window: resynchronise on this edge
          half_seen <= 1'b0;
        end
      end
      else if (gap > CNT_W'(bpc_pkg::RX_FULL_HI))
      begin
        locked <= 1'b0;
        half_seen <= 1'b0;
      end
      else
        gap <= gap + bpc_pkg::CNT_ONE;
    end
  end
endmodule : bpc_rx_decoder

// *** logic/bpc_codec.sv ***
// Biphase mark codec top: encoder, pin steering and decoder
`timescale 1ns/10ps
module bpc_codec #(
  parameter int unsigned UI_CYC = bpc_pkg::UI_CYC,
  parameter int unsigned CNT_W = bpc_pkg::CNT_W
) (
  input wire logic core_clk, // Core clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic supply_good, // Power-on supervisor good
  input wire logic orient_b, // Cable orientation, 1 selects line b
  input wire bpc_pkg::bpc_tx_bit_t tx_bit, // Bit to send
  output logic tx_ready, // Encoder took tx_bit at the clock edge that started this cycle
  output logic tx_busy, // Transmission in progress
  input wire logic channel_line_a_in, // Line a level
  output logic channel_line_a_out, // Line a drive value
  output logic channel_line_a_oe, // Line a drive enable
  input wire logic channel_line_b_in, // Line b level
  output logic channel_line_b_out, // Line b drive value
  output logic channel_line_b_oe, // Line b drive enable
  output bpc_pkg::bpc_rx_bit_t rx_bit // Decoded bits
);
  localparam logic [CNT_W-1:0] UI_LAST = CNT_W'(UI_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_AT = CNT_W'(UI_CYC / 2);

  logic core_rst;
  bpc_pkg::bpc_tx_state_t state;
  logic [CNT_W-1:0] cnt;
  logic level;
  logic cur_bit;
  logic cur_last;
  logic drive;
  logic sel_b;
  logic rx_line;
  logic rx_bit_int_valid;
  bpc_pkg::bpc_rx_bit_t rx_int;

  // Logic stays in reset until supply is good
  assign core_rst = rst | ~supply_good;

  // Transmit sequencer: preamble low, coded cells, closing edge
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
    begin
      state <= bpc_pkg::BPC_TX_IDLE;
      cnt <= bpc_pkg::CNT_ZERO;
      level <= 1'b0;
      cur_bit <= 1'b0;
      cur_last <= 1'b0;
      tx_ready <= 1'b0;
    end
    else if (ce)
    begin
      tx_ready <= 1'b0;
      case (state)
        bpc_pkg::BPC_TX_IDLE:
        begin
          if (tx_bit.valid)
          begin
            state <= bpc_pkg::BPC_TX_PRE;
            level <= 1'b0;
            cnt <= bpc_pkg::CNT_ZERO;
          end
        end
        bpc_pkg::BPC_TX_PRE:
        begin
          // One half cell of low before the first coded edge
          if (cnt == HALF_AT)
          begin
            state <= bpc_pkg::BPC_TX_BIT;
            cnt <= bpc_pkg::CNT_ZERO;
            level <= ~level;
            cur_bit <= tx_bit.data;
            cur_last <= tx_bit.last;
            tx_ready <= 1'b1;
          end
          else
            cnt <= cnt + bpc_pkg::CNT_ONE;
        end
        bpc_pkg::BPC_TX_BIT:
        begin
          if (cnt == HALF_AT && cur_bit)
            level <= ~level;
          if (cnt == UI_LAST)
          begin
            cnt <= bpc_pkg::CNT_ZERO;
            level <= ~level;
            if (cur_last || !tx_bit.valid)
              state <= bpc_pkg::BPC_TX_CLOSE;
            else
            begin
              cur_bit <= tx_bit.data;
              cur_last <= tx_bit.last;
              tx_ready <= 1'b1;
            end
          end
          else
            cnt <= cnt + bpc_pkg::CNT_ONE;
        end
        bpc_pkg::BPC_TX_CLOSE:
        begin
          // Hold the closing edge for half a cell, then release
          if (cnt == HALF_AT)
          begin
            state <= bpc_pkg::BPC_TX_IDLE;
            cnt <= bpc_pkg::CNT_ZERO;
            level <= 1'b0;
          end
          else
            cnt <= cnt + bpc_pkg::CNT_ONE;
        end
        default:
          state <= bpc_pkg::BPC_TX_IDLE;
      endcase
    end
  end

  assign drive = (state != bpc_pkg::BPC_TX_IDLE);

  // Orientation latched only while idle so a packet never switches pins
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
      sel_b <= 1'b0;
    else if (ce && !drive)
      sel_b <= orient_b;
  end

  // Registered pin drivers, only the selected pin is ever enabled
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
    begin
      channel_line_a_out <= 1'b0;
      channel_line_a_oe <= 1'b0;
      channel_line_b_out <= 1'b0;
      channel_line_b_oe <= 1'b0;
      tx_busy <= 1'b0;
    end
    else if (ce)
    begin
      channel_line_a_out <= level & ~sel_b;
      channel_line_b_out <= level & sel_b;
      channel_line_a_oe <= drive & ~sel_b;
      channel_line_b_oe <= drive & sel_b;
      tx_busy <= drive;
    end
  end

  // Receive from selected pin, muted while sending
  assign rx_line = sel_b ? channel_line_b_in : channel_line_a_in;

  bpc_rx_decoder #(
    .CNT_W(CNT_W)
  ) u_rx (
    .core_clk(core_clk),
    .rst(core_rst),
    .ce(ce),
    .line_in(rx_line),
    .rx_en(~drive),
    .rx_bit(rx_int)
  );

  assign rx_bit_int_valid = rx_int.valid;

  // Output register for decoded bits
  always_ff @(posedge core_clk)
  begin
    if (core_rst)
      rx_bit <= '0;
    else if (ce)
    begin
      rx_bit.valid <= rx_bit_int_valid;
      rx_bit.data <= rx_int.data;
    end
  end

  // Assertions
  chk_one_driver: assert property (@(posedge core_clk) disable iff (core_rst)
    !(channel_line_a_oe && channel_line_b_oe)) else $error("Both channel pins driven");
  chk_idle_release: assert property (@(posedge core_clk) disable iff (core_rst)
    ce && !drive |=> !channel_line_a_oe && !channel_line_b_oe) else $error("Line not released when idle");
  chk_preamble_low: assert property (@(posedge core_clk) disable iff (core_rst)
    ce && state == bpc_pkg::BPC_TX_IDLE && tx_bit.valid |=> !level) else $error("Preamble not starting low");
  chk_cell_toggle: assert property (@(posedge core_clk) disable iff (core_rst)
    ce && state == bpc_pkg::BPC_TX_BIT && cnt == UI_LAST |=> level != $past(level)) else $error("No cell edge");
  chk_zero_no_mid: assert property (@(posedge core_clk) disable iff (core_rst)
    ce && state == bpc_pkg::BPC_TX_BIT && cnt == HALF_AT && !cur_bit |=> level == $past(level))
    else $error("Mid edge on zero");
  chk_close_edge: assert property (@(posedge core_clk) disable iff (core_rst)
    ce && state == bpc_pkg::BPC_TX_BIT && cnt == UI_LAST && cur_last
    |=> state == bpc_pkg::BPC_TX_CLOSE && level != $past(level)) else $error("No closing edge");
  chk_supply_reset: assert property (@(posedge core_clk)
    !supply_good |=> state == bpc_pkg::BPC_TX_IDLE && !channel_line_a_oe && !channel_line_b_oe)
    else $error("Active without good supply");
  chk_rx_muted: assert property (@(posedge core_clk) disable iff (core_rst)
    ce && drive ##1 ce && drive ##1 ce |=> !rx_bit.valid) else $error("Decoding own transmission");
  chk_pre_pin_low: assert property (@(posedge core_clk) disable iff (core_rst)
    state == bpc_pkg::BPC_TX_PRE && $past(state) == bpc_pkg::BPC_TX_PRE
    |-> !channel_line_a_out && !channel_line_b_out) else $error("Preamble pin not low");
  chk_busy_oe: assert property (@(posedge core_clk) disable iff (core_rst)
    tx_busy == (channel_line_a_oe || channel_line_b_oe)) else $error("Busy and drive enable differ");
  chk_pin_steady: assert property (@(posedge core_clk) disable iff (core_rst)
    drive && $past(drive) |-> $stable(sel_b)) else $error("Pin changed during a packet");
  cov_one_bit: cover property (@(posedge core_clk) state == bpc_pkg::BPC_TX_BIT && cnt == HALF_AT && cur_bit);
  cov_close: cover property (@(posedge core_clk) state == bpc_pkg::BPC_TX_CLOSE);
  cov_rx_one: cover property (@(posedge core_clk) rx_bit.valid && rx_bit.data);
  cov_orient_b: cover property (@(posedge core_clk) channel_line_b_oe);
endmodule : bpc_codec

// *** tb/bpc_far_port.sv ***
// Behavioural far-side port sending coded frames on one line
`timescale 1ns/10ps
module bpc_far_port #(
  parameter int HALF = bpc_pkg::HALF_CYC
) (
  input wire logic core_clk, // Core clock
  output logic line_out, // Drive value
  output logic line_oe // Drive enable
);
  // Released at start
  initial
  begin
    line_out = 1'b0;
    line_oe = 1'b0;
  end

  // Sends n bits lsb first, optionally losing the first edge
  task automatic send(input logic [15:0] bits, input int n, input bit skip);
    int k;
    @(posedge core_clk) #1;
    line_oe = 1'b1;
    line_out = 1'b0;
    repeat (HALF) @(posedge core_clk);
    for (k = 0; k < n; k++)
    begin
      #1 if (!(skip && k == 0)) line_out = !line_out;
      repeat (HALF) @(posedge core_clk);
      #1 if (bits[k]) line_out = !line_out;
      repeat (HALF) @(posedge core_clk);
    end
    #1 line_out = !line_out;
    repeat (HALF) @(posedge core_clk);
    #1 line_oe = 1'b0;
  endtask : send
endmodule : bpc_far_port

// *** tb/tb.sv ***
// Self-checking bench for the biphase mark codec
`timescale 1ns/10ps
module tb;
  logic core_clk, rst, supply_good, orient_b, log_on, far_out, far_oe, ce, far_b;
  logic a_out, a_oe, b_out, b_oe, tx_ready, tx_busy;
  logic [15:0] rx_sr;
  int n_errors, n_checks, n_rx;
  logic q_out[$], q_oe[$], q_rdy[$];
  bpc_pkg::bpc_tx_bit_t tx_bit;
  bpc_pkg::bpc_rx_bit_t rx_bit;

  // Each line: own driver, else the far port when wired there, else pulled low
  bpc_codec u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .supply_good(supply_good), .orient_b(orient_b),
    .tx_bit(tx_bit), .tx_ready(tx_ready), .tx_busy(tx_busy),
    .channel_line_a_in(a_oe ? a_out : (far_oe && !far_b ? far_out : 1'b0)), .channel_line_a_out(a_out),
    .channel_line_a_oe(a_oe), .channel_line_b_in(b_oe ? b_out : (far_oe && far_b ? far_out : 1'b0)),
    .channel_line_b_out(b_out), .channel_line_b_oe(b_oe), .rx_bit(rx_bit));
  bpc_far_port u_far (.core_clk(core_clk), .line_out(far_out), .line_oe(far_oe));

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = !core_clk;
  end

  // Logging, receive capture and line ownership watch
  always @(posedge core_clk)
  begin
    if (log_on)
    begin
      q_out.push_back(orient_b ? b_out : a_out);
      q_oe.push_back(orient_b ? b_oe : a_oe);
      q_rdy.push_back(tx_ready);
    end
    if (rx_bit.valid === 1'b1)
    begin
      rx_sr = {rx_bit.data, rx_sr[15:1]};
      n_rx++;
    end
    if ((orient_b ? a_oe : b_oe) === 1'b1) check(1, 0, "other pin driven");
    if (far_oe && (a_oe === 1'b1 || b_oe === 1'b1)) check(1, 0, "two drivers");
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Request held while supply is bad
  task automatic supply_hold;
    @(posedge core_clk) #1;
    supply_good = 1'b0;
    tx_bit = 3'h4;
    repeat (30) @(posedge core_clk);
    #1 check({tx_busy, a_oe, b_oe, tx_ready}, 0, "active without supply");
    tx_bit = 3'h0;
    supply_good = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : supply_hold

  // Request held while the clock enable freezes the block
  task automatic ce_hold;
    @(posedge core_clk) #1;
    ce = 1'b0;
    tx_bit = 3'h4;
    repeat (30) @(posedge core_clk);
    #1 check({tx_busy, a_oe, b_oe, tx_ready}, 0, "started while frozen");
    tx_bit = 3'h0;
    ce = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : ce_hold

  // Sends a packet and judges the logged line
  task automatic tx_packet(input logic [7:0] bits, input int n, input logic ob);
    int k;
    int i;
    int w;
    int idx[$];
    @(posedge core_clk) #1;
    orient_b = ob;
    q_out.delete();
    q_oe.delete();
    q_rdy.delete();
    log_on = 1'b1;
    tx_bit = {1'b1, bits[0], n == 1};
    for (k = 0; k < n; k++)
    begin
      w = 0;
      do
      begin
        @(posedge core_clk) #1;
        w++;
      end
      while (tx_ready !== 1'b1 && w < 400);
      check(tx_busy, 1, "busy while sending");
      tx_bit = (k + 1 < n) ? {1'b1, bits[k + 1], k + 2 == n} : 3'h0;
    end
    repeat (300) @(posedge core_clk);
    log_on = 1'b0;
    check(tx_busy, 0, "busy after release");
    for (i = 0; i < q_rdy.size(); i++)
      if (q_rdy[i] === 1'b1) idx.push_back(i);
    check(idx.size(), n, "ready count");
    for (k = 0; k < idx.size() && k < n; k++)
    begin
      check(q_out[idx[k] + 40] ^ q_out[idx[k] - 40], 1, "cell start edge");
      check(q_out[idx[k] + 40] ^ q_out[idx[k] + 125], bits[k], "cell code");
      if (k > 0) check(idx[k] - idx[k - 1], bpc_pkg::UI_CYC, "cell length");
    end
    i = (idx.size() > 0) ? idx[idx.size() - 1] : 0;
    check(q_out[i + 125] ^ q_out[i + 206], 1, "closing edge");
    check(q_oe[i + 206], 1, "drive while sending");
    check(q_oe[i + 280], 0, "release when idle");
    for (k = 0; q_oe[k] !== 1'b1 && k < 200; k++);
    check(q_out[k], 0, "preamble level");
  endtask : tx_packet

  // Far port sends preamble and byte with the first edge lost
  task automatic rx_packet(input logic ob, input logic fb, input logic [7:0] pay);
    @(posedge core_clk) #1;
    orient_b = ob;
    far_b = fb;
    n_rx = 0;
    u_far.send({pay, 8'haa}, 16, 1'b1);
    repeat (20) @(posedge core_clk);
    if (ob == fb) check(rx_sr[15:8], pay, "decoded byte");
    check((ob != fb) ? n_rx : (n_rx >= 8), (ob != fb) ? 0 : 1, "decoded count");
  endtask : rx_packet

  // Main sequence
  initial
  begin
    rst = 1'b1;
    supply_good = 1'b1;
    ce = 1'b1;
    far_b = 1'b0;
    orient_b = 1'b0;
    log_on = 1'b0;
    tx_bit = 3'h0;
    rx_sr = 16'h0;
    n_errors = 0;
    n_checks = 0;
    n_rx = 0;
    repeat (16) @(posedge core_clk);
    #1 check({tx_busy, a_oe, b_oe}, 0, "outputs in reset");
    rst = 1'b0;
    supply_hold();
    ce_hold();
    tx_packet(8'h6a, 8, 1'b0);
    tx_packet(8'h95, 8, 1'b1);
    tx_packet(8'h01, 1, 1'b0);
    rx_packet(1'b0, 1'b0, 8'h4b);
    rx_packet(1'b1, 1'b0, 8'h4b);
    rx_packet(1'b1, 1'b1, 8'hd2);
    finish_test();
  end

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end
endmodule : tb
